// >>> pmc_ctrl.sv
// Power mode and clock source controller with a classic Wishbone slave
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
`include "pmc_consts.svh"

module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int SHORT_CD7_CYC = `PMC_NS_TO_CYC(`PMC_T_SHORT_CD7_NS),
  parameter int LONG_CD0_CYC  = `PMC_NS_TO_CYC(`PMC_T_LONG_CD0_NS),
  parameter int LONG_CD7_CYC  = `PMC_NS_TO_CYC(`PMC_T_LONG_CD7_NS)
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Wake sources
  input  wire logic [3:0]  ext_irq_i,
  input  wire logic        wakeup_timer_i,
  // Domain enables
  output logic             core_en_o,
  output logic             periph_en_o,
  output logic             pll_en_o,
  output logic             xtal_timer_en_o,
  output logic             irq_en_o,
  // Clock source
  output logic [1:0]       pll_src_o,
  output logic             ext_clk_en_o,
  output logic [2:0]       core_clk_div_o
);

  localparam int SHORT_CD0_CYC = `PMC_NS_TO_CYC(`PMC_T_SHORT_CD0_NS);

  // ============================================================
  // Helpers

  // Legal mode codes only
  function automatic logic mode_legal(input logic [3:0] m);
    return (m == `PMC_MODE_ACTIVE) || (m == `PMC_MODE_PAUSE) || (m == `PMC_MODE_NAP) ||
           (m == `PMC_MODE_SLEEP) || (m == `PMC_MODE_STOP);
  endfunction

  // Start-up time, linear between the divider 0 and divider 7 figures
  function automatic logic [`PMC_CNT_W-1:0] wake_cyc(input logic [2:0] cd,
                                                     input int c0,
                                                     input int c7);
    int t;
    t = c0 + ((c7 - c0) * int'(cd)) / int'(`PMC_CD_MAX);
    return `PMC_CNT_W'(t);
  endfunction

  // ============================================================
  // Bus decode
  logic       req;
  logic       wr;
  logic       wr_pwr_ctrl;
  logic       wr_pwr_key;
  logic       wr_clk_key1;
  logic       wr_clk_sel;
  logic       wr_clk_key2;
  logic       ack_q;
  logic [7:0] wbyte;

  assign req         = cyc_i && stb_i && !ack_q;
  assign wr          = req && we_i && sel_i[0];
  assign wbyte       = dat_i[7:0];
  assign wr_pwr_ctrl = wr && (adr_i == `PMC_ADR_PWR_CTRL);
  assign wr_pwr_key  = wr && (adr_i == `PMC_ADR_PWR_KEY);
  assign wr_clk_key1 = wr && (adr_i == `PMC_ADR_CLK_KEY1);
  assign wr_clk_sel  = wr && (adr_i == `PMC_ADR_CLK_SEL);
  assign wr_clk_key2 = wr && (adr_i == `PMC_ADR_CLK_KEY2);

  // One wait state; ack drops the cycle after it was given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end
  assign ack_o = ack_q;

  // ============================================================
  // Unlock sequencing: every write with sel_i[0] set counts, reads do not disturb
  logic       pwr_armed_q;
  logic       clk_armed_q;
  logic       clk_pend_q;
  logic [2:0] clk_pend_val_q;

  // Power key arms exactly the next write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwr_armed_q <= 1'b0;
    else if (wr)
      pwr_armed_q <= wr_pwr_key && (wbyte == `PMC_KEY_PWR);
  end

  // First key arms, select is held pending, second key commits it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_armed_q    <= 1'b0;
      clk_pend_q     <= 1'b0;
      clk_pend_val_q <= `PMC_CLK_RST;
    end
    else if (wr)
    begin
      clk_armed_q <= wr_clk_key1 && (wbyte == `PMC_KEY_CLK1);
      clk_pend_q  <= wr_clk_sel && clk_armed_q;
      if (wr_clk_sel)
        clk_pend_val_q <= wbyte[2:0];
    end
  end

  // ============================================================
  // Clock source select register
  logic [2:0] clk_sel_q;

  // Committed only by the matching second key right after the select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clk_sel_q <= `PMC_CLK_RST;
    else if (wr_clk_key2 && clk_pend_q && wbyte == `PMC_KEY_CLK2)
      clk_sel_q <= clk_pend_val_q;
  end

  // Reference choice; the pin input is shut when not selected
  always_comb
  begin
    if (clk_sel_q[`PMC_BIT_EXTERNAL_CLOCK_SELECT])
      pll_src_o = PMC_SRC_EXT_PIN;
    else if (clk_sel_q[1:0] == `PMC_OSCILLATOR_SELECT_XTAL)
      pll_src_o = PMC_SRC_XTAL;
    else
      pll_src_o = PMC_SRC_INT_OSC;
  end
  assign ext_clk_en_o = clk_sel_q[`PMC_BIT_EXTERNAL_CLOCK_SELECT];

  // ============================================================
  // Wake sources: the ext_irq_i pins cross into this clock through two flops; wakeup_timer_i is used as it comes
  logic [3:0] irq_s1_q;
  logic [3:0] irq_s2_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_s1_q <= 4'h0;
      irq_s2_q <= 4'h0;
    end
    else
    begin
      irq_s1_q <= ext_irq_i;
      irq_s2_q <= irq_s1_q;
    end
  end

  // ============================================================
  // Power mode control register and state
  logic [6:0]  pwr_q;
  pmc_state_t  state_q;
  logic        wake_ev;
  logic        tmr_busy;
  logic        tmr_done;
  logic        tmr_start;
  logic [`PMC_CNT_W-1:0] tmr_load;
  logic [3:0]  mode;

  assign mode    = pwr_q[`PMC_MODE_MSB:`PMC_MODE_LSB];
  // Timer wake only counts while the timers themselves run
  assign wake_ev = (state_q == PMC_ST_DOWN) &&
                   ((|irq_s2_q) || (wakeup_timer_i && pwr_q[`PMC_BIT_XTAL]));

  // Short figure when the PLL stayed up (pause, nap), else the long one
  always_comb
  begin
    if (pwr_q[`PMC_BIT_PLL])
      tmr_load = wake_cyc(pwr_q[`PMC_CD_MSB:`PMC_CD_LSB], SHORT_CD0_CYC, SHORT_CD7_CYC);
    else
      tmr_load = wake_cyc(pwr_q[`PMC_CD_MSB:`PMC_CD_LSB], LONG_CD0_CYC, LONG_CD7_CYC);
  end
  assign tmr_start = wake_ev;

  // Wake beats a software write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwr_q <= `PMC_PWR_RST;
    else if (wake_ev)
      pwr_q[`PMC_MODE_MSB:`PMC_MODE_LSB] <= `PMC_MODE_ACTIVE;
    else if (wr_pwr_ctrl && pwr_armed_q && mode_legal(wbyte[6:3]))
      pwr_q <= wbyte[6:0];
  end

  // Run, held down, or counting out the start-up time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= PMC_ST_RUN;
    else
    begin
      unique case (state_q)
        PMC_ST_RUN:
          if (mode != `PMC_MODE_ACTIVE)
            state_q <= PMC_ST_DOWN;
        PMC_ST_DOWN:
          if (wake_ev)
            state_q <= PMC_ST_WAKE;
        PMC_ST_WAKE:
          if (tmr_done)
            state_q <= PMC_ST_RUN;
        default:
          state_q <= PMC_ST_RUN;
      endcase
    end
  end

  pmc_wake_timer u_wake_timer
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tmr_start),
    .load_i  (tmr_load),
    .busy_o  (tmr_busy),
    .done_o  (tmr_done)
  );

  // Domain gating; the core waits out the start-up time
  assign core_en_o       = pwr_q[`PMC_BIT_CORE] && (state_q == PMC_ST_RUN);
  assign periph_en_o     = pwr_q[`PMC_BIT_PERIPH];
  assign pll_en_o        = pwr_q[`PMC_BIT_PLL];
  assign xtal_timer_en_o = pwr_q[`PMC_BIT_XTAL];
  assign irq_en_o        = 1'b1;
  assign core_clk_div_o  = pwr_q[`PMC_CD_MSB:`PMC_CD_LSB];

  // ============================================================
  // Read data, registered; key registers and unmapped read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (req && !we_i)
    begin
      unique case (adr_i)
        `PMC_ADR_PWR_CTRL: dat_o <= {25'h0, pwr_q};
        `PMC_ADR_CLK_SEL:  dat_o <= {29'h0, clk_sel_q};
        `PMC_ADR_STATUS:   dat_o <= {24'h0, clk_pend_q, clk_armed_q, pwr_armed_q,
                                     tmr_busy, 1'b0, state_q};
        default:           dat_o <= 32'h0;
      endcase
    end
  end

endmodule

// >>> pmc_consts.svh
// Constants for the power mode and clock source controller
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ============================================================
// Register byte addresses
`define PMC_ADR_PWR_CTRL    32'hFFFF0400
`define PMC_ADR_PWR_KEY     32'hFFFF040C
`define PMC_ADR_CLK_KEY1    32'hFFFF0410
`define PMC_ADR_CLK_SEL     32'hFFFF0414
`define PMC_ADR_CLK_KEY2    32'hFFFF0418
`define PMC_ADR_STATUS      32'hFFFF0420

// ============================================================
// Unlock key values
`define PMC_KEY_PWR         8'hF4
`define PMC_KEY_CLK1        8'hAA
`define PMC_KEY_CLK2        8'h55

// ============================================================
// Power mode control layout and reset value
`define PMC_PWR_RST         7'h7B
`define PMC_CD_LSB          0
`define PMC_CD_MSB          2
`define PMC_MODE_LSB        3
`define PMC_MODE_MSB        6
`define PMC_BIT_CORE        3
`define PMC_BIT_PERIPH      4
`define PMC_BIT_PLL         5
`define PMC_BIT_XTAL        6
`define PMC_MODE_ACTIVE     4'hF
`define PMC_MODE_PAUSE      4'hE
`define PMC_MODE_NAP        4'hC
`define PMC_MODE_SLEEP      4'h8
`define PMC_MODE_STOP       4'h0
`define PMC_CD_MAX          3'h7

// ============================================================
// Clock source select layout and reset value
`define PMC_CLK_RST         3'h0
`define PMC_BIT_EXTERNAL_CLOCK_SELECT      2
`define PMC_OSCILLATOR_SELECT_XTAL       2'h2

// ============================================================
// Wake-up start-up times (ns, as printed) and clock rate
`define PMC_CLK_MHZ         40
`define PMC_T_SHORT_CD0_NS  4800
`define PMC_T_SHORT_CD7_NS  660000
`define PMC_T_LONG_CD0_NS   66000
`define PMC_T_LONG_CD7_NS   900000
`define PMC_NS_TO_CYC(t)    (((t) * `PMC_CLK_MHZ) / 1000)
`define PMC_CNT_W           16

`endif

// >>> pmc_pkg.sv
// Types shared by the power mode and clock source controller
package pmc_pkg;

  // Controller state, one-hot
  typedef enum logic [2:0] {
    PMC_ST_RUN  = 3'b001,
    PMC_ST_DOWN = 3'b010,
    PMC_ST_WAKE = 3'b100
  } pmc_state_t;

  // Reference chosen for the PLL
  typedef enum logic [1:0] {
    PMC_SRC_INT_OSC = 2'h0,
    PMC_SRC_XTAL    = 2'h1,
    PMC_SRC_EXT_PIN = 2'h2
  } pmc_src_t;

endpackage

// >>> pmc_wake_timer.sv
// Start-up delay counter used while the core comes back from a low-power mode
`timescale 1ns/10ps
`include "pmc_consts.svh"

module pmc_wake_timer
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Control
  input  wire logic                  start_i,
  input  wire logic [`PMC_CNT_W-1:0] load_i,
  // Status
  output logic                       busy_o,
  output logic                       done_o
);

  logic [`PMC_CNT_W-1:0] cnt_q;
  logic                  busy_q;
  logic                  done_q;

  // Count down the loaded start-up time; a restart reloads it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_q  <= load_i;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (busy_q && cnt_q <= `PMC_CNT_W'(1))
    begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= busy_q ? cnt_q - `PMC_CNT_W'(1) : cnt_q;
      done_q <= 1'b0;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;

endmodule

// >>> pmc_ctrl_properties.sv
// Concurrent checks on the ports of the power mode and clock source controller
`timescale 1ns/10ps
`include "pmc_consts.svh"
// ============================================================
// Checker
module pmc_ctrl_props
  import pmc_pkg::*;
#(
  parameter int SHORT_CD7_CYC = 300,
  parameter int LONG_CD0_CYC  = 100,
  parameter int LONG_CD7_CYC  = 400
)
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Wake sources
  input wire logic [3:0]  ext_irq_i,
  input wire logic        wakeup_timer_i,
  // Enables and clock source
  input wire logic        core_en_o,
  input wire logic        periph_en_o,
  input wire logic        pll_en_o,
  input wire logic        xtal_timer_en_o,
  input wire logic        irq_en_o,
  input wire logic [1:0]  pll_src_o,
  input wire logic        ext_clk_en_o,
  input wire logic [2:0]  core_clk_div_o
);
  // Slowest wake plus sync slack, so the wait stays finite
  localparam int WAKE_MAX = LONG_CD7_CYC + 20;
  logic take;
  // Request taken at this edge
  assign take = cyc_i && stb_i && !ack_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_ANSWER: assert property (take |=> ack_o)
    else $error("ack missing");
  AST_ACK_DROP: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  AST_RESET_VALUES: assert property ($fell(rst_i) |-> core_clk_div_o == 3'h3
    && core_en_o && pll_src_o == 2'h0 && !ext_clk_en_o) else $error("reset values");
  AST_EXT_PIN: assert property (ext_clk_en_o == (pll_src_o == 2'h2))
    else $error("pin select");
  AST_SRC_CODE: assert property (pll_src_o != 2'h3)
    else $error("source code");
  AST_MODE_NEST: assert property ((!core_en_o || periph_en_o) && (!periph_en_o
    || pll_en_o) && (!pll_en_o || xtal_timer_en_o)) else $error("mode set");
  AST_IRQ_KEPT: assert property (irq_en_o)
    else $error("irq off");
  AST_CLK_COMMIT: assert property ($changed({pll_src_o, ext_clk_en_o}) |-> $past(take
    && we_i && adr_i == `PMC_ADR_CLK_KEY2 && dat_i[7:0] == `PMC_KEY_CLK2))
    else $error("select unlocked");
  AST_DIV_COMMIT: assert property ($changed(core_clk_div_o) |-> $past(take && we_i
    && sel_i[0] && adr_i == `PMC_ADR_PWR_CTRL)) else $error("divider unlocked");
  AST_WAKE_BOUND: assert property ((!core_en_o && ext_irq_i != 4'h0) [*3]
    |-> ##[1:WAKE_MAX] core_en_o) else $error("no wake");
endmodule
bind pmc_ctrl pmc_ctrl_props #(.SHORT_CD7_CYC(SHORT_CD7_CYC), .LONG_CD0_CYC(LONG_CD0_CYC),
  .LONG_CD7_CYC(LONG_CD7_CYC)) pmc_ctrl_props_inst (.*);

// >>> pmc_ctrl_test.sv
// Self-checking bench for the power mode and clock source controller
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_ctrl_test
  import pmc_pkg::*;
;
  // Shortened wake counts keep the run brief
  localparam int S7 = 300;
  localparam int L0 = 100;
  localparam int L7 = 400;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, wakeup_timer_i, ack_o, core_en_o;
  logic        periph_en_o, pll_en_o, xtal_timer_en_o, irq_en_o, ext_clk_en_o;
  logic [31:0] adr_i, dat_i, dat_o, rd;
  logic [3:0]  sel_i, ext_irq_i;
  logic [1:0]  pll_src_o;
  logic [2:0]  core_clk_div_o;
  int          error_cnt, comparisons, src_m, n, lo, m, cd;
  int          md[4] = '{14, 12, 8, 0};
  pmc_ctrl #(.SHORT_CD7_CYC(S7), .LONG_CD0_CYC(L0), .LONG_CD7_CYC(L7)) pmc_ctrl_inst (.*);
  // ============================================================
  // Clock
  initial
  begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ============================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 50);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (t >= 50) error_cnt++;
  endtask
  task automatic finish_test();
    $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ============================================================
  // Watchdog, well past the longest expected run
  initial
  begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end
  // ============================================================
  // Main sequence
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {4'h8, 64'h0, 4'hF};
    {ext_irq_i, wakeup_timer_i, error_cnt, comparisons} = '0;
    n = $urandom(36);
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `PMC_ADR_PWR_CTRL, 0);
    check("power_mode_control", 32'h7B, rd);
    wb(0, `PMC_ADR_CLK_SEL, 0);
    check("clock_source_select", 32'h0, rd);
    // Every select code, committed by the surrounding keys
    for (int i = 0; i < 8; i++)
    begin
      wb(1, `PMC_ADR_CLK_KEY1, 8'hAA);
      wb(1, `PMC_ADR_CLK_SEL, i);
      wb(1, `PMC_ADR_CLK_KEY2, 8'h55);
      src_m = i[2] ? 2 : (i[1:0] == 2 ? 1 : 0);
      check("pll_src_o", src_m, pll_src_o);
      check("ext_clk_en_o", i[2], ext_clk_en_o);
      wb(0, `PMC_ADR_CLK_SEL, 0);
      check("select readback", i, rd);
    end
    // Masked first key, then a stray write between the keys
    sel_i <= 4'hE;
    wb(1, `PMC_ADR_CLK_KEY1, 8'hAA);
    sel_i <= 4'hF;
    wb(1, `PMC_ADR_CLK_SEL, 2);
    wb(1, `PMC_ADR_CLK_KEY2, 8'h55);
    wb(1, `PMC_ADR_CLK_KEY1, 8'hAA);
    // A read in between leaves the armed key standing
    wb(0, `PMC_ADR_STATUS, 0);
    check("status", 32'h41, rd);
    wb(1, `PMC_ADR_CLK_SEL, 2);
    wb(1, 32'hFFFF0500, $urandom);
    wb(1, `PMC_ADR_CLK_KEY2, 8'h55);
    check("refused select", 2, pll_src_o);
    // Control write without key, then an illegal mode with key
    wb(1, `PMC_ADR_PWR_CTRL, 8'h78);
    wb(1, `PMC_ADR_PWR_KEY, 8'hF4);
    wb(1, `PMC_ADR_PWR_CTRL, 8'h53);
    check("refused divider", 3, core_clk_div_o);
    // Each low-power mode at both divider ends, then a timed wake
    for (int j = 0; j < 8; j++)
    begin
      m = md[j % 4];
      cd = j < 4 ? 0 : 7;
      wb(1, `PMC_ADR_PWR_KEY, 8'hF4);
      wb(1, `PMC_ADR_PWR_CTRL, (m << 3) | cd);
      check("domains", {2'b10, m[3:1]}, {irq_en_o, core_en_o, xtal_timer_en_o,
        pll_en_o, periph_en_o});
      lo = m[2] ? 192 + (S7 - 192) * cd / 7 : L0 + (L7 - L0) * cd / 7;
      n = 0;
      @(posedge clk_i);
      if (m == 8) wakeup_timer_i <= 1;
      else ext_irq_i <= 4'h1 << $urandom_range(3);
      do @(posedge clk_i); while (core_en_o !== 1'b1 && ++n < 2000);
      {ext_irq_i, wakeup_timer_i} <= '0;
      check("wake in window", 1, n >= lo && n <= lo + 8);
      check("woken state", {4'hF, cd[2:0]}, {xtal_timer_en_o, pll_en_o, periph_en_o,
        core_en_o, core_clk_div_o});
    end
    finish_test();
  end
endmodule
